//--- core/scg_clk_gate.sv
// Glitch-free gate for one derived clock waveform
`timescale 1ns/100ps
module scg_clk_gate
  import scg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic phase,
  input wire logic enable,
  output logic gclk
);

  logic en_hold_reg;
  logic en_hold_next;
  logic gclk_reg;
  logic gclk_next;

  // Enable only moves while the output is forced low, so no runt pulse
  always_comb begin
    en_hold_next = phase ? enable : en_hold_reg;
    gclk_next = en_hold_next & ~phase;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      en_hold_reg <= 1'b0;
      gclk_reg <= 1'b0;
    end else begin
      en_hold_reg <= en_hold_next;
      gclk_reg <= gclk_next;
    end
  end

  assign gclk = gclk_reg;

  a_full_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(gclk) |=> !gclk ##1 1'b1) else $error("gated clock pulse not one phase wide");

endmodule : scg_clk_gate

//--- core/scg_map.svh
// Register offsets, field positions, reset values and counts of the standby clock controller
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SCG_OFS_FSEL0 8'h00
`define SCG_OFS_FSEL1 8'h04
`define SCG_OFS_CLKCTL 8'h08
`define SCG_OFS_WDFSEL 8'h0C
`define SCG_OFS_STATUS 8'h10

// ==========================================================
// Field positions
`define SCG_B_STOP_INV 0
`define SCG_B_EXT_CLK 1
`define SCG_B_STOP_DONE 0
`define SCG_B_WAIT_DONE 1
`define SCG_B_STBY_SEL 2
`define SCG_B_WAIT_STOP 3
`define SCG_B_PLL_EN 1
`define SCG_B_SYS_SEL 5
`define SCG_B_WDT_SRC_LO 6
`define SCG_B_WDT_SRC_HI 7
`define SCG_B_STAT_WDT_LO 4
`define SCG_B_STAT_WDT_HI 15

// ==========================================================
// Reset values, loads and counts
`define SCG_RST_PLL_EN 1'b1
`define SCG_WDT_LOAD 12'hFFF
`define SCG_WDT_MSB 11
`define SCG_DIV_FIRST 3
`define SCG_DIV_ONES 4'hF
`define SCG_DIV_ONE 7'h01
`define SCG_WDT_ONE 12'h001

// ==========================================================
// Gated clock indices
`define SCG_NGATE 7
`define SCG_G_INPUT 0
`define SCG_G_SYS 1
`define SCG_G_BIU 2
`define SCG_G_CORE 3
`define SCG_G_PERIPH 4
`define SCG_G_WDT_A 5
`define SCG_G_WDT_B 6

`endif

//--- core/scg_pkg.sv
// Types shared by the standby clock controller
package scg_pkg;

  // ==========================================================
  // Operating states
  typedef enum logic [1:0] {
    SCG_RUN = 2'b00,
    SCG_STOP = 2'b01,
    SCG_STOP_WAKE = 2'b10,
    SCG_WAIT = 2'b11
  } scg_state_type;

  // ==========================================================
  // Software control bits
  typedef struct packed {
    logic stop_inv;
    logic ext_clk;
    logic stop_done;
    logic wait_done;
    logic standby_sel;
    logic wait_clk_stop;
    logic pll_en;
    logic sys_sel;
    logic [1:0] wdt_src;
  } scg_ctrl_type;

  // ==========================================================
  // Pin ownership: 1 means port logic drives the pin group
  typedef struct packed {
    logic addr_lo;
    logic addr_mid;
    logic addr_hi;
    logic data_lo;
    logic data_hi;
    logic read_strobe;
    logic low_byte_write_strobe;
    logic high_byte_write_strobe;
    logic chip_select_zero;
  } scg_pin_own_type;

endpackage : scg_pkg

//--- core/scg_standby.sv
// Standby controller: stop and wait modes, clock gating and bus pin handover
// ==========================================================
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_standby
  import scg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic irq_accept,
  input wire logic byte_bus_pin,
  output logic osc_run,
  output logic pll_run,
  output logic sys_clk_from_pll,
  output logic [`SCG_NGATE-1:0] gated_clocks,
  output logic [3:0] standby_divide_clocks,
  output logic event_count_only,
  output logic adc_stopped,
  output logic watchdog_stopped,
  output scg_pin_own_type pin_own
);

  // ==========================================================
  // State
  scg_state_type state_reg;
  scg_state_type state_next;
  scg_ctrl_type ctrl_reg;
  scg_ctrl_type ctrl_next;
  logic [11:0] wdt_reg;
  logic [11:0] wdt_next;
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic phase_reg;
  logic phase_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [2:0] byte_sync_reg;
  logic [2:0] byte_sync_next;
  logic byte_mode_reg;
  logic byte_mode_next;

  logic [`SCG_NGATE-1:0] gate_en;
  logic sel_fall;
  logic stop_taken;
  logic standby;
  logic wake_by_wdt;
  logic [2:0] sel_idx;

  // ==========================================================
  // Byte-bus strap: three stages, accept once last two agree
  always_comb begin
    byte_sync_next = {byte_sync_reg[1:0], byte_bus_pin};
    byte_mode_next = (byte_sync_reg[1] == byte_sync_reg[2]) ? byte_sync_reg[2] : byte_mode_reg;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      byte_sync_reg <= 3'h0;
      byte_mode_reg <= 1'b0;
    end else begin
      byte_sync_reg <= byte_sync_next;
      byte_mode_reg <= byte_mode_next;
    end
  end

  // ==========================================================
  // Standby divide clocks and the base phase of gated clocks
  always_comb begin
    sel_idx = 3'(`SCG_DIV_FIRST) + {1'b0, ctrl_reg.wdt_src};
    div_next = div_reg + `SCG_DIV_ONE;
    sel_fall = div_reg[sel_idx] & ~div_next[sel_idx];
    phase_next = ~phase_reg;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 7'h00;
      phase_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
    end
  end

  // ==========================================================
  // Mode sequencing, watchdog wake count and registers
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    wdt_next = wdt_reg;
    stop_taken = stop_instruction & ~ctrl_reg.stop_inv;
    wake_by_wdt = ~ctrl_reg.ext_clk | ctrl_reg.sys_sel;
    // Software writes go first so hardware sets below win
    if (reg_wr) begin
      unique case (reg_addr)
        `SCG_OFS_FSEL0: begin
          ctrl_next.stop_inv = reg_wdata[`SCG_B_STOP_INV];
          ctrl_next.ext_clk = reg_wdata[`SCG_B_EXT_CLK];
        end
        `SCG_OFS_FSEL1: begin
          ctrl_next.stop_done = reg_wdata[`SCG_B_STOP_DONE];
          ctrl_next.wait_done = reg_wdata[`SCG_B_WAIT_DONE];
          ctrl_next.standby_sel = reg_wdata[`SCG_B_STBY_SEL];
          ctrl_next.wait_clk_stop = reg_wdata[`SCG_B_WAIT_STOP];
        end
        `SCG_OFS_CLKCTL: begin
          ctrl_next.pll_en = reg_wdata[`SCG_B_PLL_EN];
          // PLL selection refused while the PLL is disabled
          ctrl_next.sys_sel = reg_wdata[`SCG_B_SYS_SEL] & reg_wdata[`SCG_B_PLL_EN];
        end
        `SCG_OFS_WDFSEL: begin
          ctrl_next.wdt_src = reg_wdata[`SCG_B_WDT_SRC_HI:`SCG_B_WDT_SRC_LO];
        end
        default: begin
        end
      endcase
    end
    unique case (state_reg)
      SCG_RUN: begin
        if (stop_taken) begin
          state_next = SCG_STOP;
          wdt_next = `SCG_WDT_LOAD;
          ctrl_next.stop_done = 1'b1;
        end else if (wait_instruction) begin
          state_next = SCG_WAIT;
          ctrl_next.wait_done = 1'b1;
        end
      end
      SCG_STOP: begin
        if (irq_accept) begin
          state_next = SCG_STOP_WAKE;
        end
      end
      SCG_STOP_WAKE: begin
        if (wake_by_wdt) begin
          if (!wdt_reg[`SCG_WDT_MSB]) begin
            state_next = SCG_RUN;
          end else if (sel_fall) begin
            wdt_next = wdt_reg - `SCG_WDT_ONE;
          end
        end else if (sel_fall) begin
          state_next = SCG_RUN;
        end
      end
      SCG_WAIT: begin
        if (irq_accept) begin
          state_next = SCG_RUN;
        end
      end
    endcase
  end

  // Reset forces RUN so the core clocks resume with the oscillator
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SCG_RUN;
      ctrl_reg <= '{stop_inv: 1'b0, ext_clk: 1'b0, stop_done: 1'b0, wait_done: 1'b0,
                    standby_sel: 1'b0, wait_clk_stop: 1'b0, pll_en: `SCG_RST_PLL_EN,
                    sys_sel: 1'b0, wdt_src: 2'b00};
      wdt_reg <= `SCG_WDT_LOAD;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      wdt_reg <= wdt_next;
    end
  end

  // ==========================================================
  // Read port: data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `SCG_OFS_FSEL0: begin
          rdata_next[`SCG_B_STOP_INV] = ctrl_reg.stop_inv;
          rdata_next[`SCG_B_EXT_CLK] = ctrl_reg.ext_clk;
        end
        `SCG_OFS_FSEL1: begin
          rdata_next[`SCG_B_STOP_DONE] = ctrl_reg.stop_done;
          rdata_next[`SCG_B_WAIT_DONE] = ctrl_reg.wait_done;
          rdata_next[`SCG_B_STBY_SEL] = ctrl_reg.standby_sel;
          rdata_next[`SCG_B_WAIT_STOP] = ctrl_reg.wait_clk_stop;
        end
        `SCG_OFS_CLKCTL: begin
          rdata_next[`SCG_B_PLL_EN] = ctrl_reg.pll_en;
          rdata_next[`SCG_B_SYS_SEL] = ctrl_reg.sys_sel;
        end
        `SCG_OFS_WDFSEL: begin
          rdata_next[`SCG_B_WDT_SRC_HI:`SCG_B_WDT_SRC_LO] = ctrl_reg.wdt_src;
        end
        `SCG_OFS_STATUS: begin
          rdata_next[1:0] = state_reg;
          rdata_next[`SCG_B_STAT_WDT_HI:`SCG_B_STAT_WDT_LO] = wdt_reg;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Clock enables per mode
  always_comb begin
    standby = (state_reg == SCG_STOP) || (state_reg == SCG_WAIT);
    osc_run = (state_reg != SCG_STOP) && !(standby && ctrl_reg.ext_clk);
    pll_run = ctrl_reg.pll_en && (state_reg != SCG_STOP);
    gate_en[`SCG_G_INPUT] = (state_reg != SCG_STOP);
    gate_en[`SCG_G_SYS] = (state_reg != SCG_STOP) && !(state_reg == SCG_WAIT && ctrl_reg.wait_clk_stop);
    gate_en[`SCG_G_BIU] = (state_reg == SCG_RUN);
    gate_en[`SCG_G_CORE] = (state_reg == SCG_RUN);
    gate_en[`SCG_G_PERIPH] = gate_en[`SCG_G_SYS];
    gate_en[`SCG_G_WDT_A] = (state_reg == SCG_RUN) || (state_reg == SCG_STOP_WAKE);
    gate_en[`SCG_G_WDT_B] = gate_en[`SCG_G_WDT_A];
    event_count_only = !gate_en[`SCG_G_PERIPH];
    adc_stopped = !gate_en[`SCG_G_PERIPH];
    watchdog_stopped = standby;
    sys_clk_from_pll = ctrl_reg.sys_sel;
    // Handover also spans the wake count, still part of stop
    pin_own.addr_lo = ctrl_reg.standby_sel && (state_reg != SCG_RUN);
    pin_own.addr_mid = pin_own.addr_lo;
    pin_own.addr_hi = pin_own.addr_lo;
    pin_own.data_lo = pin_own.addr_lo;
    pin_own.read_strobe = pin_own.addr_lo;
    pin_own.low_byte_write_strobe = pin_own.addr_lo;
    pin_own.chip_select_zero = pin_own.addr_lo;
    pin_own.data_hi = pin_own.addr_lo || byte_mode_reg;
    pin_own.high_byte_write_strobe = pin_own.addr_lo || byte_mode_reg;
  end

  // Divide clocks parked high while stopped
  assign standby_divide_clocks = (state_reg == SCG_STOP) ? `SCG_DIV_ONES : div_reg[6:3];

  genvar gi;
  generate
    for (gi = 0; gi < `SCG_NGATE; gi++) begin : g_gate
      scg_clk_gate u_gate (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .phase(phase_reg),
        .enable(gate_en[gi]),
        .gclk(gated_clocks[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Checks
  sequence seq_stop_taken;
    state_reg == SCG_RUN && stop_instruction && !ctrl_reg.stop_inv;
  endsequence

  sequence seq_wdt_expired;
    state_reg == SCG_STOP_WAKE && wake_by_wdt && !wdt_reg[`SCG_WDT_MSB];
  endsequence

  a_stop_entry_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    seq_stop_taken |=> state_reg == SCG_STOP && wdt_reg == `SCG_WDT_LOAD && ctrl_reg.stop_done)
    else $error("stop entry did not load watchdog");
  a_stop_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_RUN && stop_instruction && ctrl_reg.stop_inv && !wait_instruction |=> state_reg == SCG_RUN)
    else $error("stop taken while invalidated");
  a_stop_clocks: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_STOP |-> !osc_run && !pll_run && standby_divide_clocks == `SCG_DIV_ONES ##2 gated_clocks == 7'h00)
    else $error("clocks running in stop");
  a_wdt_wake: assert property (@(posedge clk_sys) disable iff (!rstn)
    seq_wdt_expired |=> state_reg == SCG_RUN ##3 gated_clocks[`SCG_G_CORE] || $past(gated_clocks[`SCG_G_CORE]))
    else $error("core clock not resumed after watchdog count");
  a_ext_wake_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_STOP_WAKE && !wake_by_wdt && !sel_fall |=> state_reg == SCG_STOP_WAKE)
    else $error("resumed before divide clock fell");
  a_wait_resume: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_WAIT && irq_accept |=> state_reg == SCG_RUN && gate_en[`SCG_G_BIU])
    else $error("wait exit delayed");
  a_wait_gating: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_WAIT |-> !gate_en[`SCG_G_BIU] && !gate_en[`SCG_G_WDT_A]
      && gate_en[`SCG_G_SYS] == !ctrl_reg.wait_clk_stop && osc_run == !ctrl_reg.ext_clk)
    else $error("wrong gating in wait");
  a_pin_handover: assert property (@(posedge clk_sys) disable iff (!rstn)
    pin_own.chip_select_zero == (ctrl_reg.standby_sel && state_reg != SCG_RUN)
      && (!byte_mode_reg || (pin_own.data_hi && pin_own.high_byte_write_strobe)))
    else $error("bus pin ownership wrong");
  a_done_bit_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == SCG_RUN && !stop_taken && wait_instruction |=> ctrl_reg.wait_done && state_reg == SCG_WAIT)
    else $error("wait done bit not set");

endmodule : scg_standby

//--- verification/scg_core_model.sv
// Core and interrupt side model: issues standby instructions and interrupt accepts
`timescale 1ns/100ps
module scg_core_model (
  input wire logic clk_sys,
  output logic stop_instruction,
  output logic wait_instruction,
  output logic irq_accept
);
  initial begin
    stop_instruction = 1'b0;
    wait_instruction = 1'b0;
    irq_accept = 1'b0;
  end

  // ==========================================================
  // One-cycle pulses, launched just after a rising edge
  task automatic exec_stop();
    @(posedge clk_sys);
    stop_instruction <= 1'b1;
    @(posedge clk_sys);
    stop_instruction <= 1'b0;
  endtask : exec_stop

  task automatic exec_wait();
    @(posedge clk_sys);
    wait_instruction <= 1'b1;
    @(posedge clk_sys);
    wait_instruction <= 1'b0;
  endtask : exec_wait

  // Only issued while a standby mode is pending, as the interrupt logic would
  task automatic accept_irq();
    @(posedge clk_sys);
    irq_accept <= 1'b1;
    @(posedge clk_sys);
    irq_accept <= 1'b0;
  endtask : accept_irq
endmodule : scg_core_model

//--- verification/scg_standby_bench.sv
// Self-checking bench of the standby clock controller
`timescale 1ns/100ps
`include "scg_map.svh"
`define CHK(g, e) chk_t(16'(g), 16'(e))
module scg_standby_bench;
  import scg_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic stop_instruction, wait_instruction, irq_accept;
  logic byte_bus_pin = 1'b0;
  logic osc_run, pll_run, sys_clk_from_pll, event_count_only, adc_stopped, watchdog_stopped;
  logic [`SCG_NGATE-1:0] gated_clocks;
  logic [3:0] standby_divide_clocks;
  scg_pin_own_type pin_own;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [15:0] rv;
  logic seen;

  always #10 clk_sys = ~clk_sys;

  scg_core_model core_u (.clk_sys(clk_sys), .stop_instruction(stop_instruction),
    .wait_instruction(wait_instruction), .irq_accept(irq_accept));

  scg_standby dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_instruction(stop_instruction),
    .wait_instruction(wait_instruction), .irq_accept(irq_accept), .byte_bus_pin(byte_bus_pin),
    .osc_run(osc_run), .pll_run(pll_run), .sys_clk_from_pll(sys_clk_from_pll),
    .gated_clocks(gated_clocks), .standby_divide_clocks(standby_divide_clocks),
    .event_count_only(event_count_only), .adc_stopped(adc_stopped),
    .watchdog_stopped(watchdog_stopped), .pin_own(pin_own));

  // ==========================================================
  // Checking and closing
  task automatic chk_t(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_t

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Long enough for one watchdog-timed wake plus the short scenarios
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end

  // ==========================================================
  // Register bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // Any high sample of one gated clock over four cycles
  task automatic active(input int idx);
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_sys);
      #1 seen = seen | gated_clocks[idx];
    end
  endtask : active

  // Cycles until the bus unit clock runs again
  task automatic wait_biu(input int lim);
    n = 0;
    seen = 1'b0;
    while (seen !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1 seen = gated_clocks[`SCG_G_BIU];
      n++;
    end
  endtask : wait_biu

  // ==========================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`SCG_OFS_CLKCTL);
    `CHK(rv, 16'h0002);
    rd(`SCG_OFS_FSEL0);
    `CHK(rv, 16'h0000);
    rd(8'h2C);
    `CHK(rv, 16'h0000);
    `CHK(pin_own, 16'h0000);
    wr(`SCG_OFS_CLKCTL, 16'h0022);
    #1 `CHK(sys_clk_from_pll, 1'b1);
    wr(`SCG_OFS_CLKCTL, 16'h0020);
    rd(`SCG_OFS_CLKCTL);
    `CHK(rv, 16'h0000);
    `CHK(pll_run, 1'b0);
    wr(`SCG_OFS_CLKCTL, 16'h0002);
    wr(`SCG_OFS_FSEL0, 16'h0001);
    core_u.exec_stop();
    rd(`SCG_OFS_STATUS);
    `CHK(rv[1:0], 2'h0);
    wr(`SCG_OFS_FSEL0, 16'h0000);
    wr(`SCG_OFS_WDFSEL, 16'h0000);
    wr(`SCG_OFS_FSEL1, 16'h0004);
    core_u.exec_stop();
    #1 `CHK({osc_run, pll_run, standby_divide_clocks}, 6'h0F);
    `CHK({adc_stopped, watchdog_stopped, event_count_only}, 3'h7);
    `CHK(pin_own, 16'h01FF);
    rd(`SCG_OFS_STATUS);
    `CHK(rv, 16'hFFF1);
    rd(`SCG_OFS_FSEL1);
    `CHK(rv, 16'h0005);
    active(`SCG_G_CORE);
    `CHK(seen | gated_clocks[`SCG_G_INPUT] | gated_clocks[`SCG_G_WDT_B], 1'b0);
    core_u.accept_irq();
    #1 `CHK(osc_run, 1'b1);
    wait_biu(40000);
    `CHK(n >= 32760 && n <= 32830, 1'b1);
    `CHK(pin_own, 16'h0000);
    wr(`SCG_OFS_FSEL1, 16'h0000);
    wr(`SCG_OFS_FSEL0, 16'h0002);
    wr(`SCG_OFS_WDFSEL, 16'h00C0);
    core_u.exec_stop();
    #1 `CHK(osc_run, 1'b0);
    core_u.accept_irq();
    wait_biu(200);
    `CHK(n <= 131, 1'b1);
    `CHK(standby_divide_clocks, 4'h0);
    core_u.exec_wait();
    #1 `CHK(osc_run, 1'b0);
    rd(`SCG_OFS_FSEL1);
    `CHK(rv, 16'h0003);
    `CHK({adc_stopped, watchdog_stopped, event_count_only}, 3'h2);
    active(`SCG_G_SYS);
    `CHK(seen, 1'b1);
    active(`SCG_G_BIU);
    `CHK(seen | gated_clocks[`SCG_G_WDT_A], 1'b0);
    core_u.accept_irq();
    wait_biu(4);
    `CHK(seen, 1'b1);
    wr(`SCG_OFS_FSEL0, 16'h0000);
    wr(`SCG_OFS_FSEL1, 16'h0008);
    core_u.exec_wait();
    #1 `CHK({osc_run, adc_stopped, event_count_only}, 3'h7);
    active(`SCG_G_SYS);
    `CHK(seen | gated_clocks[`SCG_G_PERIPH], 1'b0);
    active(`SCG_G_INPUT);
    `CHK(seen, 1'b1);
    core_u.accept_irq();
    wr(`SCG_OFS_FSEL1, 16'h0000);
    rd(`SCG_OFS_STATUS);
    `CHK(rv[1:0], 2'h0);
    core_u.exec_stop();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`SCG_OFS_STATUS);
    `CHK(rv[1:0], 2'h0);
    active(`SCG_G_CORE);
    `CHK(seen, 1'b1);
    @(posedge clk_sys);
    byte_bus_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 `CHK(pin_own, 16'h0012);
    close_out();
  end
endmodule : scg_standby_bench
